// File: src/pidl_position_loop.sv
// How it works
// [RULE1] Each sample the error is the target value minus the measured value of that sample.
// [RULE2] Integral coefficient is gain times sample period over integral period; derivative coefficient is gain times rate period over sample period.
// [RULE3] Derivative action uses the change in measured value, not the change in error.
// [RULE4] Integral sum and initial output share one accumulated bias, loaded with the initial output.
// [RULE5] Candidate bias is integral coefficient times error plus old bias; raw output is gain times error minus derivative coefficient times measured change plus bias.
// [RULE6] The normalized output is clamped to the nearer of 0.0 and 1.0.
// [RULE7] User minimum and maximum output limits in 0 to 4095 bound the 12 bit output.
// [RULE8] The normalized accumulated bias is kept within 0.0 to 1.0.
// [RULE9] A setup bit selects freezing or adjusting the bias for anti-windup.
// [RULE10] With freeze selected, an out-of-range raw output keeps the old bias, else the candidate is taken.
// [RULE11] A mode bit selects position output or velocity output, the change needed.
// [RULE12] With adjust selected and output out of range, bias becomes clamped output minus proportional term with derivative term removed.
// [RULE13] With zero gain the coefficients are the bare period ratios.
// [RULE14] One full update runs per sample tick and the measured value becomes the previous sample.
`timescale 1ns/1ps
module pidl_position_loop
  import pidl_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic                     i_sample_tick,
  input  wire logic                     i_load_bias,
  input  wire logic        [DATA_W-1:0] i_measured_value,
  input  wire logic        [DATA_W-1:0] i_target_value,
  input  wire logic        [DATA_W-1:0] i_initial_output,
  input  wire pidl_config_s             i_config,
  output logic             [DATA_W-1:0] o_control_value,
  output logic signed      [DATA_W:0]   o_control_delta,
  output pidl_val_t                     o_accumulated_bias,
  output logic                          o_update_done,
  output logic                          o_busy,
  output logic                          o_clamped_low,
  output logic                          o_clamped_high
);

  // ----------------------------------------------------------------
  // Format check
  // ----------------------------------------------------------------
  if (FRAC < DATA_W || NUM_W != VAL_W || GAIN_W >= VAL_W) begin : g_bad_format
    $error("pidl_position_loop: fixed-point format not supported");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pidl_state_e         state;
    logic                div_start;
    logic [NUM_W-1:0]    div_num;
    logic [PERIOD_W-1:0] div_den;
    pidl_config_s        cfg;
    pidl_val_t           measured_value;
    pidl_val_t           target_value;
    pidl_val_t           prev_measured;
    pidl_val_t           prev2_measured;
    pidl_val_t           prev_error;
    pidl_val_t           ratio_i;
    pidl_val_t           proportional_gain;
    pidl_val_t           integral_coefficient;
    pidl_val_t           derivative_coefficient;
    pidl_val_t           error;
    pidl_val_t           p_term;
    pidl_val_t           d_term;
    pidl_val_t           bias_candidate;
    pidl_val_t           raw_output;
    pidl_val_t           raw_delta;
    pidl_val_t           accumulated_bias;
    logic [DATA_W-1:0]   control_value;
    logic [DATA_W:0]     control_delta;
    logic                update_done;
    logic                busy;
    logic                clamped_low;
    logic                clamped_high;
  } pidl_loop_s;

  pidl_loop_s st;
  pidl_loop_s next_st;

  // ----------------------------------------------------------------
  // Coefficient divider
  // ----------------------------------------------------------------
  logic [NUM_W-1:0] div_quotient;
  logic             div_done;

  pidl_divider #(
    .NUM_BITS (NUM_W),
    .DEN_BITS (PERIOD_W)
  ) u_divider (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_start       (st.div_start),
    .i_numerator   (st.div_num),
    .i_denominator (st.div_den),
    .o_quotient    (div_quotient),
    .o_done        (div_done)
  );

  // ----------------------------------------------------------------
  // Output, bias and limit clamps
  // ----------------------------------------------------------------
  pidl_val_t out_clamped;
  logic      out_below;
  logic      out_above;
  pidl_val_t bias_select;
  pidl_val_t bias_clamped;
  pidl_val_t delta_clamped;
  logic      delta_below;
  logic      delta_above;
  pidl_val_t out_scaled;
  pidl_val_t out_limited;
  pidl_val_t delta_scaled;
  pidl_val_t out_final;

  pidl_clamp #(.W(VAL_W)) u_out_clamp (
    .i_value (st.raw_output),
    .i_low   (VAL_ZERO),
    .i_high  (VAL_ONE),
    .o_value (out_clamped),
    .o_below (out_below),
    .o_above (out_above)
  );

  // ----------------------------------------------------------------
  // Bias clamp
  // ----------------------------------------------------------------
  pidl_clamp #(.W(VAL_W)) u_bias_clamp (
    .i_value (bias_select),
    .i_low   (VAL_ZERO),
    .i_high  (VAL_ONE),
    .o_value (bias_clamped),
    .o_below (),
    .o_above ()
  );

  // ----------------------------------------------------------------
  // Velocity delta clamp
  // ----------------------------------------------------------------
  pidl_clamp #(.W(VAL_W)) u_delta_clamp (
    .i_value (st.raw_delta),
    .i_low   (VAL_NEG1),
    .i_high  (VAL_ONE),
    .o_value (delta_clamped),
    .o_below (delta_below),
    .o_above (delta_above)
  );

  // ----------------------------------------------------------------
  // User output limits
  // ----------------------------------------------------------------
  pidl_clamp #(.W(VAL_W)) u_limit_clamp (
    .i_value (out_scaled),
    .i_low   (pidl_val_t'(st.cfg.out_min)),
    .i_high  (pidl_val_t'(st.cfg.out_max)),
    .o_value (out_limited),
    .o_below (),
    .o_above ()
  );

  // ----------------------------------------------------------------
  // Anti-windup bias choice and output scaling
  // ----------------------------------------------------------------
  always_comb begin
    if (!(out_below || out_above)) begin
      bias_select = st.bias_candidate;  // [RULE10]
    end else if (st.cfg.freeze_bias) begin  // [RULE9]
      bias_select = st.accumulated_bias;  // [RULE10]
    end else begin
      bias_select = fx_add(fx_sub(out_clamped, st.p_term), st.d_term);  // [RULE12]
    end
    out_scaled   = fx_mul(out_clamped, VAL_SCALE);
    delta_scaled = fx_mul(delta_clamped, VAL_SCALE);
    if (st.cfg.out_min > st.cfg.out_max) begin
      out_final = pidl_val_t'(st.cfg.out_max);  // [RULE7]
    end else begin
      out_final = out_limited;  // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    pidl_val_t dpv;
    pidl_val_t d2pv;
    dpv                 = VAL_ZERO;
    d2pv                = VAL_ZERO;
    next_st             = st;
    next_st.div_start   = 1'b0;
    next_st.update_done = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
        if (i_sample_tick) begin  // [RULE14]
          next_st.cfg            = i_config;
          next_st.measured_value = fx_norm(i_measured_value);
          next_st.target_value   = fx_norm(i_target_value);
          next_st.proportional_gain = pidl_val_t'(i_config.proportional_gain);
          next_st.div_num   = {i_config.sample_period, {FRAC{1'b0}}};  // [RULE2]
          next_st.div_den   = i_config.integral_period;
          next_st.div_start = 1'b1;
          next_st.state     = ST_DIV_I;
          next_st.busy      = 1'b1;  // [RULE14]
        end else if (i_load_bias) begin
          next_st.accumulated_bias = fx_norm(i_initial_output);  // [RULE4]
          next_st.prev_measured    = fx_norm(i_measured_value);
          next_st.prev2_measured   = fx_norm(i_measured_value);
          next_st.prev_error       = VAL_ZERO;
        end
      end
      ST_DIV_I: begin
        if (div_done) begin
          next_st.ratio_i   = fx_from_u(div_quotient);
          next_st.div_num   = {st.cfg.rate_period, {FRAC{1'b0}}};  // [RULE2]
          next_st.div_den   = st.cfg.sample_period;
          next_st.div_start = 1'b1;
          next_st.state     = ST_DIV_R;
        end
      end
      ST_DIV_R: begin
        if (div_done) begin
          if (st.proportional_gain == VAL_ZERO) begin
            next_st.integral_coefficient   = st.ratio_i;  // [RULE13]
            next_st.derivative_coefficient = fx_from_u(div_quotient);  // [RULE13]
          end else begin
            next_st.integral_coefficient   = fx_mul(st.proportional_gain, st.ratio_i);  // [RULE2]
            next_st.derivative_coefficient =
              fx_mul(st.proportional_gain, fx_from_u(div_quotient));  // [RULE2]
          end
          next_st.state = ST_COEF;
        end
      end
      ST_COEF: begin
        next_st.error  = fx_sub(st.target_value, st.measured_value);  // [RULE1]
        next_st.state  = ST_CALC;
      end
      ST_CALC: begin
        dpv  = fx_sub(st.measured_value, st.prev_measured);  // [RULE3]
        d2pv = fx_add(fx_sub(dpv, st.prev_measured), st.prev2_measured);
        next_st.p_term = fx_mul(st.proportional_gain, st.error);  // [RULE5]
        next_st.d_term = fx_mul(st.derivative_coefficient, dpv);  // [RULE3]
        next_st.bias_candidate =
          fx_add(fx_mul(st.integral_coefficient, st.error), st.accumulated_bias);  // [RULE5]
        next_st.raw_output = fx_add(
          fx_sub(fx_mul(st.proportional_gain, st.error),
                 fx_mul(st.derivative_coefficient, dpv)),
          fx_add(fx_mul(st.integral_coefficient, st.error), st.accumulated_bias));  // [RULE5]
        next_st.raw_delta = fx_sub(
          fx_add(fx_mul(st.proportional_gain, fx_sub(st.error, st.prev_error)),
                 fx_mul(st.integral_coefficient, st.error)),
          fx_mul(st.derivative_coefficient, d2pv));  // [RULE11]
        next_st.state = ST_APPLY;
      end
      ST_APPLY: begin
        if (st.cfg.velocity_mode) begin  // [RULE11]
          next_st.control_delta = delta_scaled[DATA_W:0];
          next_st.clamped_low   = delta_below;
          next_st.clamped_high  = delta_above;
        end else begin
          next_st.accumulated_bias = bias_clamped;  // [RULE8]
          next_st.control_value    = out_final[DATA_W-1:0];  // [RULE6] [RULE7]
          next_st.clamped_low      = out_below;  // [RULE6]
          next_st.clamped_high     = out_above;  // [RULE6]
        end
        next_st.prev2_measured = st.prev_measured;
        next_st.prev_measured  = st.measured_value;  // [RULE14]
        next_st.prev_error     = st.error;
        next_st.update_done    = 1'b1;
        next_st.busy           = 1'b0;
        next_st.state          = ST_IDLE;
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st                  <= '0;
      st.state            <= ST_IDLE;
      st.accumulated_bias <= BIAS_RST;
      st.control_value    <= OUT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_control_value    = st.control_value;
  assign o_control_delta    = st.control_delta;
  assign o_accumulated_bias = st.accumulated_bias;
  assign o_update_done      = st.update_done;
  assign o_busy             = st.busy;
  assign o_clamped_low      = st.clamped_low;
  assign o_clamped_high     = st.clamped_high;

endmodule

// File: src/pidl_pkg.sv
package pidl_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed-point format
  // ----------------------------------------------------------------
  localparam int FRAC     = 16;
  localparam int VAL_W    = 32;
  localparam int DATA_W   = 12;
  localparam int PERIOD_W = 16;
  localparam int GAIN_W   = 24;
  localparam int NUM_W    = PERIOD_W + FRAC;

  typedef logic signed [VAL_W-1:0]   pidl_val_t;
  typedef logic signed [2*VAL_W-1:0] pidl_wide_t;

  // ----------------------------------------------------------------
  // Constants and reset values
  // ----------------------------------------------------------------
  localparam pidl_val_t  VAL_ZERO  = 32'sh0000_0000;
  localparam pidl_val_t  VAL_ONE   = 32'sh0001_0000;
  localparam pidl_val_t  VAL_NEG1  = 32'shffff_0000;
  localparam pidl_val_t  VAL_MAX   = 32'sh7fff_ffff;
  localparam pidl_val_t  VAL_MIN   = 32'sh8000_0000;
  localparam pidl_val_t  VAL_SCALE = 32'sh0000_0fff;
  localparam pidl_wide_t WIDE_MAX  = 64'sh0000_0000_7fff_ffff;
  localparam pidl_wide_t WIDE_MIN  = 64'shffff_ffff_8000_0000;
  localparam pidl_val_t  BIAS_RST  = 32'sh0000_0000;
  localparam logic [DATA_W-1:0] OUT_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DIV_I = 6'h02,
    ST_DIV_R = 6'h04,
    ST_COEF  = 6'h08,
    ST_CALC  = 6'h10,
    ST_APPLY = 6'h20
  } pidl_state_e;

  typedef struct packed {
    logic [GAIN_W-1:0]   proportional_gain;
    logic [PERIOD_W-1:0] sample_period;
    logic [PERIOD_W-1:0] integral_period;
    logic [PERIOD_W-1:0] rate_period;
    logic                freeze_bias;
    logic                velocity_mode;
    logic [DATA_W-1:0]   out_min;
    logic [DATA_W-1:0]   out_max;
  } pidl_config_s;

  // ----------------------------------------------------------------
  // Saturating fixed-point arithmetic
  // ----------------------------------------------------------------
  function automatic pidl_val_t fx_sat(input pidl_wide_t w);
    if (w > WIDE_MAX) return VAL_MAX;
    if (w < WIDE_MIN) return VAL_MIN;
    return w[VAL_W-1:0];
  endfunction

  function automatic pidl_val_t fx_add(input pidl_val_t a, input pidl_val_t b);
    return fx_sat(pidl_wide_t'(a) + pidl_wide_t'(b));
  endfunction

  function automatic pidl_val_t fx_sub(input pidl_val_t a, input pidl_val_t b);
    return fx_sat(pidl_wide_t'(a) - pidl_wide_t'(b));
  endfunction

  function automatic pidl_val_t fx_mul(input pidl_val_t a, input pidl_val_t b);
    pidl_wide_t p;
    p = pidl_wide_t'(a) * pidl_wide_t'(b);
    return fx_sat(p >>> FRAC);
  endfunction

  function automatic pidl_val_t fx_norm(input logic [DATA_W-1:0] raw);
    return pidl_val_t'({raw, {(FRAC-DATA_W){1'b0}}});
  endfunction

  function automatic pidl_val_t fx_from_u(input logic [NUM_W-1:0] q);
    return q[NUM_W-1] ? VAL_MAX : pidl_val_t'(q);
  endfunction

endpackage

// File: src/pidl_divider.sv
`timescale 1ns/1ps
module pidl_divider
  import pidl_pkg::*;
#(
  parameter int NUM_BITS = NUM_W,
  parameter int DEN_BITS = PERIOD_W
) (
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  input  wire logic                i_start,
  input  wire logic [NUM_BITS-1:0] i_numerator,
  input  wire logic [DEN_BITS-1:0] i_denominator,
  output logic      [NUM_BITS-1:0] o_quotient,
  output logic                     o_done
);

  localparam int CNT_W = $clog2(NUM_BITS + 1);

  if (NUM_BITS < 2 || DEN_BITS < 1) begin : g_bad_width
    $error("pidl_divider: unsupported widths");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                busy;
    logic                done;
    logic [CNT_W-1:0]    count;
    logic [NUM_BITS-1:0] num;
    logic [DEN_BITS-1:0] den;
    logic [DEN_BITS:0]   rem;
    logic [NUM_BITS-1:0] quo;
  } pidl_div_s;

  pidl_div_s st;
  pidl_div_s next_st;

  // ----------------------------------------------------------------
  // Restoring division, one quotient bit per cycle
  // ----------------------------------------------------------------
  always_comb begin
    logic [DEN_BITS:0] shifted;
    shifted      = '0;
    next_st      = st;
    next_st.done = 1'b0;
    if (i_start && !st.busy) begin
      next_st.busy  = 1'b1;
      next_st.count = CNT_W'(NUM_BITS);
      next_st.num   = i_numerator;
      next_st.den   = i_denominator;
      next_st.rem   = '0;
      next_st.quo   = '0;
    end else if (st.busy) begin
      shifted     = {st.rem[DEN_BITS-1:0], st.num[NUM_BITS-1]};
      next_st.num = {st.num[NUM_BITS-2:0], 1'b0};
      if (shifted >= {1'b0, st.den}) begin
        next_st.rem = shifted - {1'b0, st.den};
        next_st.quo = {st.quo[NUM_BITS-2:0], 1'b1};
      end else begin
        next_st.rem = shifted;
        next_st.quo = {st.quo[NUM_BITS-2:0], 1'b0};
      end
      next_st.count = st.count - CNT_W'(1);
      if (st.count == CNT_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_quotient = st.quo;
  assign o_done     = st.done;

endmodule

// File: src/pidl_clamp.sv
`timescale 1ns/1ps
module pidl_clamp #(
  parameter int W = 32
) (
  input  wire logic signed [W-1:0] i_value,
  input  wire logic signed [W-1:0] i_low,
  input  wire logic signed [W-1:0] i_high,
  output logic signed      [W-1:0] o_value,
  output logic                     o_below,
  output logic                     o_above
);

  if (W < 2) begin : g_bad_width
    $error("pidl_clamp: width too small");
  end

  // ----------------------------------------------------------------
  // Clamp to nearer bound
  // ----------------------------------------------------------------
  always_comb begin
    o_below = i_value < i_low;
    o_above = !o_below && (i_value > i_high);
    if (o_below) begin
      o_value = i_low;
    end else if (o_above) begin
      o_value = i_high;
    end else begin
      o_value = i_value;
    end
  end

endmodule

// File: verification/pidl_loop_sva.sv
`timescale 1ns/1ps
module pidl_loop_sva
  import pidl_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic              i_sample_tick,
  input wire pidl_config_s      i_config,
  input wire logic [DATA_W-1:0] o_control_value,
  input wire pidl_val_t         o_accumulated_bias,
  input wire logic              o_update_done,
  input wire logic              o_busy,
  input wire logic              o_clamped_low,
  input wire logic              o_clamped_high
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic lim_ok;
  logic pos;
  assign lim_ok = i_config.out_min <= i_config.out_max;
  assign pos    = !i_config.velocity_mode;
  chk_tick_busy: assert property (i_sample_tick && !o_busy |=> o_busy)
    else $error("busy did not rise after tick");
  chk_done_time: assert property (i_sample_tick && !o_busy |-> ##[69:73] o_update_done)
    else $error("update done missing after tick");
  chk_done_pulse: assert property (o_update_done |=> !o_update_done)
    else $error("update done longer than one cycle");
  chk_out_hold: assert property (!o_update_done |-> $stable(o_control_value))
    else $error("output moved without update");
  chk_bias_range: assert property (o_accumulated_bias >= 0 && o_accumulated_bias <= VAL_ONE)
    else $error("bias outside zero to one");
  chk_flag_excl: assert property (!(o_clamped_low && o_clamped_high))
    else $error("both clamp flags set");
  chk_out_limit: assert property (o_update_done && pos |-> o_control_value <= i_config.out_max && (o_control_value >= i_config.out_min || !lim_ok))
    else $error("output outside user limits");
  chk_high_out: assert property (o_update_done && pos && o_clamped_high |-> o_control_value == i_config.out_max)
    else $error("high clamp not at upper bound");
  chk_low_out: assert property (o_update_done && pos && o_clamped_low |-> o_control_value == (lim_ok ? i_config.out_min : i_config.out_max))
    else $error("low clamp not at lower bound");
  chk_freeze_hold: assert property (o_update_done && pos && i_config.freeze_bias && (o_clamped_low || o_clamped_high) |-> $stable(o_accumulated_bias))
    else $error("frozen bias changed");
  chk_vel_bias: assert property (o_update_done && !pos |-> $stable(o_accumulated_bias))
    else $error("bias changed in velocity mode");
endmodule

// File: verification/pidl_plant_model.sv
`timescale 1ns/1ps
module pidl_plant_model
  import pidl_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_update_done,
  input  wire logic [DATA_W-1:0] i_control_value,
  input  wire logic [DATA_W-1:0] i_disturb,
  output logic      [DATA_W-1:0] o_measured_value
);
  // ------------------------------------------------------------
  // Plant moves a quarter toward the drive, plus disturbance
  // ------------------------------------------------------------
  int pv;
  int nx;
  assign nx = pv + (int'(i_control_value) - pv) / 4 + int'(i_disturb) - 64;
  always_ff @(posedge i_clock) begin
    if (i_rst) pv <= 2048;
    else if (i_update_done) pv <= nx < 0 ? 0 : (nx > 4095 ? 4095 : nx);
  end
  assign o_measured_value = pv[DATA_W-1:0];
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pidl_pkg::*;
  logic                   i_clock = 0, i_rst = 1, i_sample_tick = 0, i_load_bias = 0;
  logic      [DATA_W-1:0] i_target_value = 0, i_initial_output = 0, disturb = 0, pv;
  pidl_config_s           i_config = '0;
  logic      [DATA_W-1:0] o_control_value;
  logic signed [DATA_W:0] o_control_delta;
  pidl_val_t              o_accumulated_bias;
  logic                   o_update_done, o_busy, o_clamped_low, o_clamped_high;
  int                     n_errors = 0, cmp_count = 0, seed;
  longint                 mx, pv1, p, e, dp, ki, kr, kc, m, mc, bx, cv, pv2, e1, dv;

  pidl_position_loop dut (.i_clock(i_clock), .i_rst(i_rst), .i_sample_tick(i_sample_tick),
    .i_load_bias(i_load_bias), .i_measured_value(pv), .i_target_value(i_target_value),
    .i_initial_output(i_initial_output), .i_config(i_config),
    .o_control_value(o_control_value), .o_control_delta(o_control_delta),
    .o_accumulated_bias(o_accumulated_bias), .o_update_done(o_update_done), .o_busy(o_busy),
    .o_clamped_low(o_clamped_low), .o_clamped_high(o_clamped_high));
  pidl_plant_model plant (.i_clock(i_clock), .i_rst(i_rst), .i_update_done(o_update_done),
    .i_control_value(o_control_value), .i_disturb(disturb), .o_measured_value(pv));

  always #10 i_clock = ~i_clock;

  // ------------------------------------------------------------
  // Compare, verdict and loop update tasks
  // ------------------------------------------------------------
  task automatic check(input logic signed [63:0] seen, input longint exp, input int tol);
    cmp_count++;
    if ($isunknown(seen) || seen > exp + tol || seen + tol < exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Tick held one extra cycle and a load pulse while busy: both ignored
  task automatic run_tick;
    int k;
    @(posedge i_clock);
    i_sample_tick <= 1;
    @(negedge i_clock);
    p = pv;
    @(posedge i_clock);
    @(posedge i_clock);
    i_sample_tick <= 0;
    i_load_bias <= 1;
    @(posedge i_clock);
    i_load_bias <= 0;
    for (k = 0; k < 200 && o_update_done !== 1'b1; k++) @(negedge i_clock);
    if (k == 200) begin
      n_errors++;
      stop_test();
    end
  endtask

  task automatic model_cmp;
    longint np;
    longint dc;
    np = p << 4;
    kc = i_config.proportional_gain;
    ki = (longint'(i_config.sample_period) << 16) / i_config.integral_period;
    kr = (longint'(i_config.rate_period) << 16) / i_config.sample_period;
    if (kc != 0) begin
      ki = (kc * ki) >>> 16;
      kr = (kc * kr) >>> 16;
    end
    e = (longint'(i_target_value) << 4) - np;
    dp = np - pv1;
    if (i_config.velocity_mode) begin
      dv = ((kc * (e - e1)) >>> 16) + ((ki * e) >>> 16) - ((kr * (dp - pv1 + pv2)) >>> 16);
      dc = dv < -65536 ? -65536 : (dv > 65536 ? 65536 : dv);
      check(o_control_delta, (dc * 4095) >>> 16, 1);
      check(o_clamped_low, dv < -65536, 0);
      check(o_clamped_high, dv > 65536, 0);
      check(o_accumulated_bias, mx, 0);
    end else begin
      bx = ((ki * e) >>> 16) + mx;
      m = ((kc * e) >>> 16) - ((kr * dp) >>> 16) + bx;
      mc = m < 0 ? 0 : (m > 65536 ? 65536 : m);
      if (m != mc) bx = i_config.freeze_bias ? mx : mc - ((kc * e) >>> 16) + ((kr * dp) >>> 16);
      mx = bx < 0 ? 0 : (bx > 65536 ? 65536 : bx);
      cv = (mc * 4095) >>> 16;
      if (cv < i_config.out_min) cv = i_config.out_min;
      if (cv > i_config.out_max) cv = i_config.out_max;
      check(o_control_value, cv, 1);
      check(o_accumulated_bias, mx, 8);
      check(o_clamped_low, m < 0, 0);
      check(o_clamped_high, m > 65536, 0);
    end
    pv2 = pv1;
    pv1 = np;
    e1 = e;
    check(o_busy, 0, 0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(23433);
    repeat (3) @(posedge i_clock);
    i_rst <= 0;
    @(negedge i_clock);
    check(o_accumulated_bias, 0, 0);
    check(o_control_value, 0, 0);
    check(o_busy, 0, 0);
    $display("test reset done");
    @(posedge i_clock);
    i_initial_output <= 12'($urandom_range(4095));
    i_load_bias <= 1;
    @(posedge i_clock);
    i_load_bias <= 0;
    mx = longint'(i_initial_output) << 4;
    pv1 = longint'(pv) << 4;
    pv2 = pv1;
    @(negedge i_clock);
    check(o_accumulated_bias, mx, 0);
    $display("test load done");
    for (int i = 0; i < 28; i++) begin
      @(posedge i_clock);
      i_config.proportional_gain <= (i % 4 == 3) ? 24'h0 : 24'($urandom_range(262143));
      i_config.sample_period <= 16'($urandom_range(200, 50));
      i_config.integral_period <= 16'($urandom_range(2200, 200));
      i_config.rate_period <= 16'($urandom_range(400));
      i_config.freeze_bias <= 1'($urandom_range(1));
      i_config.velocity_mode <= (i >= 24);
      i_config.out_min <= i % 2 ? 12'h000 : 12'($urandom_range(1000));
      i_config.out_max <= i % 2 ? 12'hfff : 12'($urandom_range(4095, 3000));
      i_target_value <= 12'($urandom_range(4095));
      i_initial_output <= 12'($urandom_range(4095));
      disturb <= 12'($urandom_range(127));
      run_tick();
      model_cmp();
      if (i == 23) $display("test loop done");
    end
    $display("test velocity done");
    stop_test();
  end
endmodule

bind pidl_position_loop pidl_loop_sva u_sva (.i_clock(i_clock), .i_rst(i_rst),
  .i_sample_tick(i_sample_tick), .i_config(i_config), .o_control_value(o_control_value),
  .o_accumulated_bias(o_accumulated_bias), .o_update_done(o_update_done), .o_busy(o_busy),
  .o_clamped_low(o_clamped_low), .o_clamped_high(o_clamped_high));
